// [design/mitd_decoder.sv]
// Instruction timing decoder with dual data pointers and timer prescale.
// Assumes a core that presents an opcode with a one-cycle strobe and drives SFR accesses.
//
// Function
// RULE1 - One instruction cycle lasts four system clocks.
// RULE2 - Every instruction lasts one to nine instruction cycles per its opcode.
// RULE3 - External data moves take two plus clock-control low three bits cycles.
// RULE4 - E2-E3, E0, F2-F3, F0 are one-byte external moves, register or pointer.
// RULE5 - 93 reads code at acc plus pointer, 83 at acc plus PC; three cycles.
// RULE6 - Opcode 90 loads pointer immediate: three bytes, three cycles.
// RULE7 - Stack store C0 and pull D0: two bytes, two cycles.
// RULE8 - Exchanges C8-CF, C5, C6-C7 and nibble swap D6-D7 decode as given.
// RULE9 - Short calls three cycles; long call, returns four cycles.
// RULE10 - Page jump 3, long jump 4, relative 3, indirect 73 3 cycles.
// RULE11 - Carry branches three cycles; bit branches four; 10 clears the bit.
// RULE12 - Acc zero 60 and nonzero 70 branches: two bytes, three cycles.
// RULE13 - Compare-branch opcodes: three bytes, four cycles.
// RULE14 - Decrement-branch D8-DF two bytes three cycles; D5 three bytes four.
// RULE15 - 00 is idle; reserved A5 behaves the same.
// RULE16 - Memory accesses equal byte count; product and divide exceed it. The table has no product or divide entry; they decode as unknown, one cycle.
// RULE17 - Timers step every twelve clocks by default, four when configured.
// RULE18 - Two 16-bit pointers at 82/83 and 84/85.
// RULE19 - Select bit 0 at 86 picks the active pointer for all pointer uses.
// RULE20 - Select register implements only bit 0; others read zero.
// RULE21 - Software toggles the pointer by incrementing the select register.
// RULE22 - Select bit resets to zero, first pointer active.
module mitd_decoder #(
  parameter int CLOCKS_PER_CYCLE = mitd_pkg::CLOCKS_PER_CYCLE
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Instruction issue
  input wire logic issue_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] reg_ptr_in,
  // Special-function access
  input wire logic sfr_write_in,
  input wire logic sfr_read_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // Decode answer
  output logic busy_out,
  output logic done_out,
  output logic [1:0] bytes_out,
  output logic [3:0] cycles_out,
  output logic mem_access_out,
  output logic [15:0] mem_addr_out,
  output logic clear_bit_out,
  output logic unknown_out,
  // Pointers and timer
  output logic [15:0] active_data_pointer_out,
  output logic timer_tick_out
);
  if (CLOCKS_PER_CYCLE != mitd_pkg::CLOCKS_PER_CYCLE) begin : g_cycle_check
    $error("Cycle length must be four clocks");
  end

  localparam logic [1:0] PHASE_LAST = 2'(CLOCKS_PER_CYCLE - 1);
  localparam logic [3:0] SLOW_LAST = 4'(mitd_pkg::TIMER_SLOW_CLOCKS - 1);
  localparam logic [3:0] FAST_LAST = 4'(mitd_pkg::TIMER_FAST_CLOCKS - 1);
  // Opcodes that change state here, not only timing
  localparam logic [7:0] OP_LOAD_POINTER = 8'h90;
  localparam logic [7:0] OP_BIT_CLEAR = 8'h10;

  // Pointer and control registers
  logic [7:0] ptr0_low;
  logic [7:0] ptr0_high;
  logic [7:0] ptr1_low;
  logic [7:0] ptr1_high;
  logic [7:0] clock_control;
  logic ptr_select;
  logic [7:0] next_ptr0_low;
  logic [7:0] next_ptr0_high;
  logic [7:0] next_ptr1_low;
  logic [7:0] next_ptr1_high;
  logic [7:0] next_clock_control;
  logic next_ptr_select;
  logic [7:0] next_sfr_rdata;
  logic next_sfr_hit;
  logic [15:0] next_active_pointer;
  logic [15:0] first_data_pointer;
  logic [15:0] second_data_pointer;
  logic [15:0] active_data_pointer;
  // Declared early: the pointer load watches the sequence state
  mitd_pkg::mitd_state_e state;
  mitd_pkg::mitd_state_e next_state;

  assign first_data_pointer = {ptr0_high, ptr0_low}; // RULE18
  assign second_data_pointer = {ptr1_high, ptr1_low};
  assign active_data_pointer = ptr_select ? second_data_pointer : first_data_pointer; // RULE19

  always_comb begin
    next_ptr0_low = ptr0_low;
    next_ptr0_high = ptr0_high;
    next_ptr1_low = ptr1_low;
    next_ptr1_high = ptr1_high;
    next_ptr_select = ptr_select;
    next_clock_control = clock_control;
    next_sfr_rdata = 8'h00;
    next_sfr_hit = 1'b0;
    if (sfr_write_in) begin
      unique case (sfr_addr_in)
        mitd_pkg::SFR_PTR0_LOW: next_ptr0_low = sfr_wdata_in; // RULE18
        mitd_pkg::SFR_PTR0_HIGH: next_ptr0_high = sfr_wdata_in;
        mitd_pkg::SFR_PTR1_LOW: next_ptr1_low = sfr_wdata_in;
        mitd_pkg::SFR_PTR1_HIGH: next_ptr1_high = sfr_wdata_in;
        // An increment of the select register lands here as a write of value plus one
        mitd_pkg::SFR_PTR_SELECT: next_ptr_select = sfr_wdata_in[mitd_pkg::SELECT_BIT]; // RULE20 RULE21
        mitd_pkg::SFR_CLOCK_CONTROL: next_clock_control = sfr_wdata_in;
        default: ;
      endcase
    end
    // Immediate pointer load goes to whichever pointer is active at issue
    if (state == mitd_pkg::MITD_IDLE && issue_in && opcode_in == OP_LOAD_POINTER) begin
      if (ptr_select) begin
        next_ptr1_high = acc_in; // RULE6 RULE19
        next_ptr1_low = reg_ptr_in;
      end else begin
        next_ptr0_high = acc_in; // RULE6
        next_ptr0_low = reg_ptr_in;
      end
    end
    // Read data come from the registers, so a write in the same cycle reads back the old value
    if (sfr_read_in) begin
      next_sfr_hit = 1'b1;
      unique case (sfr_addr_in)
        mitd_pkg::SFR_PTR0_LOW: next_sfr_rdata = ptr0_low;
        mitd_pkg::SFR_PTR0_HIGH: next_sfr_rdata = ptr0_high;
        mitd_pkg::SFR_PTR1_LOW: next_sfr_rdata = ptr1_low;
        mitd_pkg::SFR_PTR1_HIGH: next_sfr_rdata = ptr1_high;
        mitd_pkg::SFR_PTR_SELECT: next_sfr_rdata = {7'h00, ptr_select}; // RULE20
        mitd_pkg::SFR_CLOCK_CONTROL: next_sfr_rdata = clock_control;
        default: next_sfr_hit = 1'b0;
      endcase
    end
    // Output follows a select write in the very next cycle
    next_active_pointer = next_ptr_select ? {next_ptr1_high, next_ptr1_low}
                                          : {next_ptr0_high, next_ptr0_low}; // RULE19
  end

  // Decode sequence
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [3:0] cycles_left;
  logic [3:0] next_cycles_left;
  logic [1:0] tbl_bytes;
  logic [3:0] tbl_cycles;
  mitd_pkg::mitd_addr_e tbl_addr;
  logic tbl_known;
  logic next_busy;
  logic next_done;
  logic next_mem_access;
  logic next_clear_bit;
  logic next_unknown;
  logic [1:0] next_bytes;
  logic [3:0] next_cycles;
  logic [15:0] next_mem_addr;

  mitd_opcode_table u_table (
    .opcode_in(opcode_in),
    .stretch_in(clock_control[mitd_pkg::STRETCH_MSB:mitd_pkg::STRETCH_LSB]),
    .bytes_out(tbl_bytes),
    .cycles_out(tbl_cycles),
    .addr_out(tbl_addr),
    .known_out(tbl_known)
  );

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cycles_left = cycles_left;
    next_busy = busy_out;
    next_done = 1'b0;
    next_bytes = bytes_out;
    next_cycles = cycles_out;
    next_mem_access = mem_access_out;
    next_mem_addr = mem_addr_out;
    next_clear_bit = clear_bit_out;
    next_unknown = unknown_out;
    // An issue outside idle is dropped silently; the core waits for done
    unique case (state)
      mitd_pkg::MITD_IDLE: begin
        if (issue_in) begin
          next_state = mitd_pkg::MITD_RUN;
          next_phase = 2'h0;
          // Unlisted opcodes (other groups) get one cycle here and are flagged
          next_cycles_left = tbl_cycles; // RULE2
          next_busy = 1'b1;
          next_bytes = tbl_bytes; // RULE16
          next_cycles = tbl_cycles;
          next_unknown = ~tbl_known;
          next_clear_bit = (opcode_in == OP_BIT_CLEAR); // RULE11
          next_mem_access = (tbl_addr != mitd_pkg::MITD_ADDR_NONE);
          unique case (tbl_addr)
            mitd_pkg::MITD_ADDR_REG8: next_mem_addr = {8'h00, reg_ptr_in}; // RULE4
            mitd_pkg::MITD_ADDR_ACTIVE_DATA_POINTER: next_mem_addr = active_data_pointer; // RULE4 RULE19
            mitd_pkg::MITD_ADDR_ACC_ACTIVE_DATA_POINTER: next_mem_addr = active_data_pointer + {8'h00, acc_in}; // RULE5
            mitd_pkg::MITD_ADDR_ACC_PC: next_mem_addr = pc_in + {8'h00, acc_in}; // RULE5
            default: next_mem_addr = 16'h0000;
          endcase
        end
      end
      mitd_pkg::MITD_RUN: begin
        // Phase wraps every four clocks, so instruction cycles stay aligned to the issue edge
        next_phase = phase + 2'h1;
        if (phase == PHASE_LAST) begin
          next_phase = 2'h0; // RULE1
          next_cycles_left = cycles_left - 4'h1;
          if (cycles_left == 4'h1) begin
            // Access and bit-clear flags drop with busy, giving one clean window
            next_state = mitd_pkg::MITD_DONE;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_mem_access = 1'b0;
            next_clear_bit = 1'b0;
          end
        end
      end
      mitd_pkg::MITD_DONE: begin
        next_state = mitd_pkg::MITD_IDLE;
      end
      default: next_state = mitd_pkg::MITD_IDLE;
    endcase
  end

  // Timer prescale
  logic [3:0] prescale;
  logic [3:0] next_prescale;
  logic next_tick;

  always_comb begin
    next_prescale = prescale + 4'h1;
    next_tick = 1'b0;
    // Greater-or-equal, so a switch to the fast rate mid-count wraps at once
    if (prescale >= (clock_control[mitd_pkg::TIMER_FAST_BIT] ? FAST_LAST : SLOW_LAST)) begin
      next_prescale = 4'h0; // RULE17
      next_tick = 1'b1;
    end
  end

  // Pointer and control state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr0_low <= mitd_pkg::PTR_RESET;
      ptr0_high <= mitd_pkg::PTR_RESET;
      ptr1_low <= mitd_pkg::PTR_RESET;
      ptr1_high <= mitd_pkg::PTR_RESET;
      ptr_select <= mitd_pkg::PTR_SELECT_RESET; // RULE22
      clock_control <= mitd_pkg::CLOCK_CONTROL_RESET;
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
      active_data_pointer_out <= 16'h0000;
    end else begin
      ptr0_low <= next_ptr0_low;
      ptr0_high <= next_ptr0_high;
      ptr1_low <= next_ptr1_low;
      ptr1_high <= next_ptr1_high;
      ptr_select <= next_ptr_select;
      clock_control <= next_clock_control;
      sfr_rdata_out <= next_sfr_rdata;
      sfr_hit_out <= next_sfr_hit;
      active_data_pointer_out <= next_active_pointer;
    end
  end

  // Decode state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= mitd_pkg::MITD_IDLE;
      phase <= 2'h0;
      cycles_left <= 4'h0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      bytes_out <= 2'h0;
      cycles_out <= 4'h0;
      mem_access_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      clear_bit_out <= 1'b0;
      unknown_out <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cycles_left <= next_cycles_left;
      busy_out <= next_busy;
      done_out <= next_done;
      bytes_out <= next_bytes;
      cycles_out <= next_cycles;
      mem_access_out <= next_mem_access;
      mem_addr_out <= next_mem_addr;
      clear_bit_out <= next_clear_bit;
      unknown_out <= next_unknown;
    end
  end

  // Prescale state
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale <= 4'h0;
      timer_tick_out <= 1'b0;
    end else begin
      prescale <= next_prescale;
      timer_tick_out <= next_tick;
    end
  end
endmodule

// [shared/mitd_pkg.sv]
// Package for the instruction timing decoder with dual data pointers.
// Assumes a single system clock; used by the design only, the bench files use literal values.
package mitd_pkg;
  // Special-function addresses
  localparam logic [7:0] SFR_PTR0_LOW = 8'h82;
  localparam logic [7:0] SFR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] SFR_PTR1_LOW = 8'h84;
  localparam logic [7:0] SFR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] SFR_PTR_SELECT = 8'h86;
  localparam logic [7:0] SFR_CLOCK_CONTROL = 8'h8e;
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam logic PTR_SELECT_RESET = 1'b0;
  // Field positions
  localparam int SELECT_BIT = 0;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;
  localparam int TIMER_FAST_BIT = 3;
  // Timing
  localparam int CLOCKS_PER_CYCLE = 4;
  localparam int TIMER_SLOW_CLOCKS = 12;
  localparam int TIMER_FAST_CLOCKS = 4;
  localparam int XDATA_BASE_CYCLES = 2;
  // Operand source of a decoded instruction
  typedef enum logic [2:0] {
    MITD_ADDR_NONE = 3'h0,
    MITD_ADDR_REG8 = 3'h1,
    MITD_ADDR_ACTIVE_DATA_POINTER = 3'h2,
    MITD_ADDR_ACC_ACTIVE_DATA_POINTER = 3'h3,
    MITD_ADDR_ACC_PC = 3'h4
  } mitd_addr_e;
  // Decoder sequence
  typedef enum logic [2:0] {
    MITD_IDLE = 3'b001,
    MITD_RUN = 3'b010,
    MITD_DONE = 3'b100
  } mitd_state_e;
endpackage

// [design/mitd_opcode_table.sv]
// Opcode table: bytes, instruction cycles and operand source per opcode.
// Assumes the caller registers the answer; purely combinational lookup.
module mitd_opcode_table (
  // Opcode and stretch
  input wire logic [7:0] opcode_in,
  input wire logic [2:0] stretch_in,
  // Answer
  output logic [1:0] bytes_out,
  output logic [3:0] cycles_out,
  output mitd_pkg::mitd_addr_e addr_out,
  output logic known_out
);
  always_comb begin
    bytes_out = 2'h1;
    cycles_out = 4'h1;
    addr_out = mitd_pkg::MITD_ADDR_NONE;
    known_out = 1'b1;
    if (opcode_in[3:0] == 4'h1) begin
      bytes_out = 2'h2; // RULE9 RULE10
      cycles_out = 4'h3;
    end else if (opcode_in[7:3] == 5'h19 || opcode_in[7:1] == 7'h63 || opcode_in[7:1] == 7'h6b) begin
      bytes_out = 2'h1; // RULE8
      cycles_out = 4'h1;
    end else if (opcode_in[7:3] == 5'h1b) begin
      bytes_out = 2'h2; // RULE14
      cycles_out = 4'h3;
    end else if (opcode_in[7:3] == 5'h17 || opcode_in[7:1] == 7'h5b) begin
      bytes_out = 2'h3; // RULE13
      cycles_out = 4'h4;
    end else begin
      unique case (opcode_in)
        8'h00, 8'ha5: begin
          bytes_out = 2'h1; // RULE15
          cycles_out = 4'h1;
        end
        8'he0, 8'hf0: begin
          addr_out = mitd_pkg::MITD_ADDR_ACTIVE_DATA_POINTER; // RULE4 RULE19
          cycles_out = 4'(mitd_pkg::XDATA_BASE_CYCLES) + {1'b0, stretch_in}; // RULE3
        end
        8'he2, 8'he3, 8'hf2, 8'hf3: begin
          addr_out = mitd_pkg::MITD_ADDR_REG8; // RULE4
          cycles_out = 4'(mitd_pkg::XDATA_BASE_CYCLES) + {1'b0, stretch_in}; // RULE3
        end
        8'h93: begin
          addr_out = mitd_pkg::MITD_ADDR_ACC_ACTIVE_DATA_POINTER; // RULE5
          cycles_out = 4'h3;
        end
        8'h83: begin
          addr_out = mitd_pkg::MITD_ADDR_ACC_PC; // RULE5
          cycles_out = 4'h3;
        end
        8'h90: begin
          bytes_out = 2'h3; // RULE6
          cycles_out = 4'h3;
          addr_out = mitd_pkg::MITD_ADDR_ACTIVE_DATA_POINTER;
        end
        8'hc0, 8'hd0, 8'hc5: begin
          bytes_out = 2'h2; // RULE7 RULE8
          cycles_out = 4'h2;
        end
        8'h12, 8'h02, 8'hd5, 8'h20, 8'h30, 8'h10: begin
          bytes_out = 2'h3; // RULE9 RULE10 RULE11 RULE14
          cycles_out = 4'h4;
        end
        8'hb5, 8'hb4: begin
          bytes_out = 2'h3; // RULE13
          cycles_out = 4'h4;
        end
        8'h22, 8'h32: begin
          cycles_out = 4'h4; // RULE9
        end
        8'h80, 8'h40, 8'h50, 8'h60, 8'h70: begin
          bytes_out = 2'h2; // RULE10 RULE11 RULE12
          cycles_out = 4'h3;
        end
        8'h73: begin
          addr_out = mitd_pkg::MITD_ADDR_ACC_ACTIVE_DATA_POINTER; // RULE10 RULE19
          cycles_out = 4'h3;
        end
        default: begin
          known_out = 1'b0;
        end
      endcase
    end
  end
endmodule

// [bench/mitd_decoder_asserts.sv]
// Checker for the instruction timing decoder.
// Assumes it is bound to mitd_decoder and sees only its ports.
module mitd_decoder_asserts #(
  parameter int CLOCKS_PER_CYCLE = 4
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic issue_in,
  input wire logic [7:0] opcode_in,
  input wire logic sfr_write_in,
  input wire logic sfr_read_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] bytes_out,
  input wire logic [3:0] cycles_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic clear_bit_out,
  input wire logic unknown_out,
  input wire logic [15:0] active_data_pointer_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] stretch;
  logic [5:0] busy_cnt;
  // Shadow of the stretch field, so the move length can be predicted
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stretch <= 3'h1;
      busy_cnt <= 6'h00;
    end else begin
      if (sfr_write_in && sfr_addr_in == 8'h8e) stretch <= sfr_wdata_in[2:0];
      busy_cnt <= done_out ? 6'h00 : busy_cnt + 6'(busy_out);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_taken;
    issue_in && !busy_out && !done_out;
  endsequence
  a_busy_follows: assert property (s_taken |=> busy_out && !done_out) else $error("busy did not follow issue");
  a_busy_length: assert property (done_out |-> busy_cnt == CLOCKS_PER_CYCLE * cycles_out) else $error("busy length");
  a_done_single: assert property (done_out |=> !done_out && !busy_out) else $error("done not single");
  a_cycle_range: assert property (done_out |-> cycles_out >= 4'h1 && cycles_out <= 4'h9) else $error("cycle range");
  a_idle_op: assert property (s_taken ##0 (opcode_in == 8'h00 || opcode_in == 8'ha5) |=>
    bytes_out == 2'h1 && cycles_out == 4'h1 && !unknown_out) else $error("idle op timing");
  a_xmove_stretch: assert property (s_taken ##0 opcode_in == 8'he0 |=>
    cycles_out == 4'h2 + 4'(stretch) && mem_addr_out == $past(active_data_pointer_out))
    else $error("external move");
  a_clear_bit: assert property (s_taken ##0 opcode_in == 8'h10 |=> cycles_out == 4'h4 ##0 clear_bit_out [*8])
    else $error("bit clear branch");
  a_select_read: assert property (sfr_read_in && sfr_addr_in == 8'h86 |=> sfr_hit_out &&
    sfr_rdata_out[7:1] == 7'h00) else $error("select read");
  a_unmapped_read: assert property (sfr_read_in && (sfr_addr_in < 8'h82 || sfr_addr_in > 8'h86) &&
    sfr_addr_in != 8'h8e |=> !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("unmapped read");
endmodule

// [bench/mitd_xmem_model.sv]
// External data memory stand-in: records the address of each access.
// Assumes the decoder holds the address steady while access is flagged.
module mitd_xmem_model (
  // Clock
  input wire logic clk_in,
  // Access from the decoder
  input wire logic mem_access_in,
  input wire logic [15:0] mem_addr_in,
  // Observation
  output logic [15:0] last_addr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clk_in) begin
    if (mem_access_in) last_addr_out <= mem_addr_in;
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the instruction timing decoder.
// Assumes the checker and memory model files are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, reset_n_in, issue_in, sfr_write_in, sfr_read_in, clr;
  logic [7:0] opcode_in, acc_in, reg_ptr_in, sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [15:0] pc_in, mem_addr_out, active_data_pointer_out, last_addr;
  logic sfr_hit_out, busy_out, done_out, mem_access_out, clear_bit_out, unknown_out, timer_tick_out;
  logic [1:0] bytes_out;
  logic [3:0] cycles_out;
  int error_cnt = 0;
  int checks_done = 0;
  // Packed as opcode, bytes, cycles; moves assume the reset stretch
  logic [15:0] tbl [] = '{16'h0011, 16'ha511, 16'h9313, 16'h8313, 16'h9033, 16'hc022, 16'hd022, 16'hc811,
    16'hcf11, 16'hc522, 16'hc611, 16'hd611, 16'hd711, 16'h1123, 16'hf123, 16'h1234, 16'h2214, 16'h3214,
    16'h0123, 16'he123, 16'h0234, 16'h8023, 16'h7313, 16'h4023, 16'h5023, 16'h2034, 16'h3034, 16'h1034,
    16'h6023, 16'h7023, 16'hb534, 16'hb434, 16'hb834, 16'hbf34, 16'hb634, 16'hd823, 16'hdf23, 16'hd534,
    16'he213, 16'he313, 16'he013, 16'hf213, 16'hf313, 16'hf013};
  mitd_decoder uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .issue_in(issue_in), .opcode_in(opcode_in),
    .acc_in(acc_in), .pc_in(pc_in), .reg_ptr_in(reg_ptr_in), .sfr_write_in(sfr_write_in),
    .sfr_read_in(sfr_read_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out), .busy_out(busy_out), .done_out(done_out),
    .bytes_out(bytes_out), .cycles_out(cycles_out), .mem_access_out(mem_access_out),
    .mem_addr_out(mem_addr_out), .clear_bit_out(clear_bit_out), .unknown_out(unknown_out),
    .active_data_pointer_out(active_data_pointer_out), .timer_tick_out(timer_tick_out));
  mitd_xmem_model xmem (.clk_in(clk_in), .mem_access_in(mem_access_out), .mem_addr_in(mem_addr_out),
    .last_addr_out(last_addr));
  initial clk_in = 1'b0;
  always #2 clk_in = ~clk_in;
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  // Each access starts with an edge so a strobe is never lowered and raised at once
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_write_in = 1'b1;
    tick();
    sfr_write_in = 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    tick();
    sfr_addr_in = a;
    sfr_read_in = 1'b1;
    tick();
    sfr_read_in = 1'b0;
    cmp("sfr data", 16'(exp), 16'(sfr_rdata_out));
    cmp("sfr hit", 16'(hit), 16'(sfr_hit_out));
  endtask
  task automatic run_op(input logic [7:0] op, input logic [7:0] acc, input logic [7:0] rp,
                        input logic [3:0] cyc, input logic [1:0] nb);
    int n;
    tick();
    opcode_in = op;
    acc_in = acc;
    reg_ptr_in = rp;
    issue_in = 1'b1;
    tick();
    issue_in = 1'b0;
    clr = clear_bit_out;
    n = 1;
    while (done_out !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    cmp("done clocks", 16'(cyc) * 16'h4 + 16'h1, 16'(n));
    cmp("cycles", 16'(cyc), 16'(cycles_out));
    cmp("bytes", 16'(nb), 16'(bytes_out));
  endtask
  task automatic t_regs();
    for (int a = 8'h82; a <= 8'h86; a++) sfr_rd(8'(a), 8'h00, 1'b1);
    sfr_rd(8'h8e, 8'h01, 1'b1);
    sfr_rd(8'h87, 8'h00, 1'b0);
  endtask
  task automatic t_table();
    foreach (tbl[i]) begin
      run_op(tbl[i][15:8], 8'h00, 8'h00, tbl[i][3:0], tbl[i][5:4]);
      cmp("decoded", 16'h0000, 16'(unknown_out));
    end
    run_op(8'h04, 8'h00, 8'h00, 4'h1, 2'h1);
    cmp("unknown flag", 16'h0001, 16'(unknown_out));
  endtask
  task automatic t_ptr();
    sfr_wr(8'h82, 8'h34);
    sfr_wr(8'h83, 8'h12);
    sfr_wr(8'h84, 8'hcd);
    sfr_wr(8'h85, 8'hab);
    sfr_rd(8'h85, 8'hab, 1'b1);
    run_op(8'he0, 8'h00, 8'h00, 4'h3, 2'h1);
    cmp("move address p0", 16'h1234, last_addr);
    sfr_wr(8'h86, 8'hff);
    sfr_rd(8'h86, 8'h01, 1'b1);
    cmp("active p1", 16'habcd, active_data_pointer_out);
    run_op(8'h93, 8'h10, 8'h00, 4'h3, 2'h1);
    cmp("code read p1", 16'habdd, last_addr);
    sfr_wr(8'h86, 8'h02);
    cmp("active p0", 16'h1234, active_data_pointer_out);
    run_op(8'h90, 8'h56, 8'h78, 4'h3, 2'h3);
    sfr_rd(8'h82, 8'h78, 1'b1);
    sfr_rd(8'h83, 8'h56, 1'b1);
    pc_in = 16'h1000;
    run_op(8'h83, 8'h05, 8'h00, 4'h3, 2'h1);
    cmp("code read pc", 16'h1005, last_addr);
    run_op(8'hf2, 8'h00, 8'h44, 4'h3, 2'h1);
    cmp("move address reg", 16'h0044, last_addr);
    run_op(8'h10, 8'h00, 8'h00, 4'h4, 2'h3);
    cmp("clear bit", 16'h0001, 16'(clr));
  endtask
  task automatic t_stretch();
    sfr_wr(8'h8e, 8'h07);
    run_op(8'hf0, 8'h00, 8'h00, 4'h9, 2'h1);
    sfr_wr(8'h8e, 8'h00);
    run_op(8'he3, 8'h00, 8'h00, 4'h2, 2'h1);
  endtask
  task automatic t_timer(input logic [7:0] cc, input int exp);
    int n;
    sfr_wr(8'h8e, cc);
    repeat (30) tick();
    n = 0;
    while (timer_tick_out !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    n = 0;
    do begin
      tick();
      n++;
    end while (timer_tick_out !== 1'b1 && n < 40);
    cmp("timer gap", 16'(exp), 16'(n));
  endtask
  initial begin
    {issue_in, sfr_write_in, sfr_read_in, reset_n_in} = 4'h0;
    {opcode_in, acc_in, reg_ptr_in, sfr_addr_in, sfr_wdata_in} = 40'h0;
    pc_in = 16'h0000;
    repeat (6) @(posedge clk_in);
    #1 reset_n_in = 1'b1;
    t_regs();
    t_table();
    t_ptr();
    t_stretch();
    t_timer(8'h01, 12);
    t_timer(8'h09, 4);
    end_sim();
  end
  // Cuts a hang short at 25000 cycles, well beyond the fewer than a thousand cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
bind mitd_decoder mitd_decoder_asserts #(.CLOCKS_PER_CYCLE(CLOCKS_PER_CYCLE)) u_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .issue_in(issue_in), .opcode_in(opcode_in), .sfr_write_in(sfr_write_in),
  .sfr_read_in(sfr_read_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out), .busy_out(busy_out), .done_out(done_out),
  .bytes_out(bytes_out), .cycles_out(cycles_out), .mem_addr_out(mem_addr_out),
  .clear_bit_out(clear_bit_out), .unknown_out(unknown_out), .active_data_pointer_out(active_data_pointer_out));
